//--- mcr_pkg.sv
`default_nettype none
package mcr_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] COMMAND_REG_OFFSET = 8'h00;
	localparam logic [31:0] COMMAND_REG_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Field positions of command_reg
	// ------------------------------------------------------------
	localparam int SOFT_RESET_BIT = 8; // Global soft reset
	localparam int SOFT_IRQ_TRIGGER_BIT = 7; // Software interrupt
	localparam int RECEIVE_PATH_RESET_BIT = 5;
	localparam int TRANSMIT_PATH_RESET_BIT = 4;
	localparam int RECEIVE_STOP_BIT = 3; // Receive disable strobe
	localparam int RECEIVE_RUN_BIT = 2;
	localparam int TRANSMIT_STOP_BIT = 1; // Transmit disable strobe
	localparam int TRANSMIT_RUN_BIT = 0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10; // 100 MHz reference clock
	localparam int SOFT_RESET_NS = 1000; // Duration of the soft reset state
	// Least time, so round up to whole cycles
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Path run state, Gray along idle -> active -> stopping
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MCR_IDLE = 2'h0,
		MCR_ACTIVE = 2'h1,
		MCR_STOPPING = 2'h3
	} mcr_path_state_t;
endpackage
`default_nettype wire

//--- mcr_path_if.sv
`timescale 1ns/1ns
`default_nettype none
// Command strobes and status between the command register and one path controller
interface mcr_path_if;
	logic enable_cmd; // One-cycle enable strobe
	logic disable_cmd; // One-cycle disable strobe
	logic reset_cmd; // One-cycle path reset strobe
	logic busy; // Engine is moving a packet
	logic active; // Path machine is not idle
	logic stop_req; // Finish current packet then stop
	logic abort; // Abort and flush pulse to the engine
	modport ctrl (
		input enable_cmd, disable_cmd, reset_cmd, busy,
		output active, stop_req, abort
	);
	modport cmd (
		output enable_cmd, disable_cmd, reset_cmd, busy,
		input active, stop_req, abort
	);
endinterface
`default_nettype wire

//--- mcr_path_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Run control for one direction (transmit or receive)
module mcr_path_ctrl (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	mcr_path_if.ctrl path
);
	mcr_pkg::mcr_path_state_t state_reg; // Current run state
	logic abort_reg; // Registered abort pulse

	// ------------------------------------------------------------
	// Run state machine
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= mcr_pkg::MCR_IDLE;
		end else if (path.reset_cmd) begin
			state_reg <= mcr_pkg::MCR_IDLE;
		end else begin
			unique case (state_reg)
				mcr_pkg::MCR_IDLE: begin
					if (path.enable_cmd && !path.disable_cmd) begin
						state_reg <= mcr_pkg::MCR_ACTIVE;
					end
				end
				mcr_pkg::MCR_ACTIVE: begin
					if (path.disable_cmd) begin
						state_reg <= mcr_pkg::MCR_STOPPING;
					end
				end
				mcr_pkg::MCR_STOPPING: begin
					// Packet done, machine goes idle
					if (!path.busy) begin
						state_reg <= mcr_pkg::MCR_IDLE;
					end
				end
				default: begin
					// Code 2 is illegal; recover to idle
					state_reg <= mcr_pkg::MCR_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Abort and flush pulse
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			abort_reg <= 1'b0;
		end else begin
			abort_reg <= path.reset_cmd;
		end
	end

	assign path.active = (state_reg != mcr_pkg::MCR_IDLE);
	assign path.stop_req = (state_reg == mcr_pkg::MCR_STOPPING);
	assign path.abort = abort_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_RESET_GOES_IDLE:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		path.reset_cmd |=> !path.active && path.abort)
	else $error("path reset did not idle and abort");

	AST_ENABLE_FROM_IDLE:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(!path.active && path.enable_cmd && !path.disable_cmd && !path.reset_cmd)
		|=> path.active)
	else $error("enable from idle did not activate");

	AST_DISABLE_WINS:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(!path.active && path.disable_cmd) |=> !path.active)
	else $error("enable was not ignored beside disable");

	AST_STOP_AFTER_PACKET:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(path.stop_req && path.busy && !path.reset_cmd) |=> path.active)
	else $error("path stopped during a packet");

	AST_STOP_CLEARS_ACTIVE:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(path.stop_req && !path.busy) |=> !path.active)
	else $error("active not cleared after stop");
endmodule
`default_nettype wire

//--- mcr_command_reg.sv
`timescale 1ns/1ns
`default_nettype none
module mcr_command_reg #(
	parameter int SOFT_RESET_CYCLES = mcr_pkg::SOFT_RESET_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic reg_wr_in, // Register write strobe
	input wire logic reg_rd_in, // Register read strobe
	input wire logic [7:0] reg_addr_in, // Byte offset
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_rd_valid_out,
	input wire logic tx_busy_in, // Transmit engine mid-packet
	input wire logic rx_busy_in, // Receive engine mid-packet
	input wire logic soft_irq_mask_in, // Mask bit from interrupt_mask_reg, 1 lets it through
	input wire logic soft_irq_ack_in, // Interrupt status read clears the request
	output logic soft_irq_req_out,
	output logic soft_reset_out, // Holds FIFOs and affected registers in reset
	output logic tx_run_out,
	output logic rx_run_out,
	output logic tx_stop_req_out,
	output logic rx_stop_req_out,
	output logic tx_abort_out, // Abort and flush transmit FIFOs
	output logic rx_abort_out // Abort and flush receive FIFOs
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
	localparam int RST_WAIT = SOFT_RESET_CYCLES + 1; // Bound for the self-clear check

	mcr_path_if tx_path (); // Transmit path carrier
	mcr_path_if rx_path (); // Receive path carrier

	logic soft_rst_reg; // Reset bit, reads one while running
	logic [CNT_W-1:0] rst_cnt_reg; // Cycles left in soft reset
	logic soft_irq_pend_reg; // Latched software interrupt
	logic [31:0] rdata_reg;
	logic rd_valid_reg;
	logic wr_hit; // Write to command_reg that is accepted
	logic rst_start; // Soft reset begins this cycle

	// Returns one when a write hits bit pos with a one
	function automatic logic cmd_bit(input logic [31:0] data, input int pos);
		cmd_bit = data[pos];
	endfunction

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	// Writes during soft reset are dropped so nothing restarts a half-reset path
	assign wr_hit = reg_wr_in && (reg_addr_in == mcr_pkg::COMMAND_REG_OFFSET) && !soft_rst_reg;
	assign rst_start = wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::SOFT_RESET_BIT);

	// soft reset drives both path resets
	assign tx_path.reset_cmd = rst_start ||
		(wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::TRANSMIT_PATH_RESET_BIT));
	assign rx_path.reset_cmd = rst_start ||
		(wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::RECEIVE_PATH_RESET_BIT));
	assign tx_path.disable_cmd = wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::TRANSMIT_STOP_BIT);
	assign rx_path.disable_cmd = wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::RECEIVE_STOP_BIT);
	assign tx_path.enable_cmd = wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::TRANSMIT_RUN_BIT) &&
		!tx_path.disable_cmd && !rst_start;
	assign rx_path.enable_cmd = wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::RECEIVE_RUN_BIT) &&
		!rx_path.disable_cmd && !rst_start;
	assign tx_path.busy = tx_busy_in;
	assign rx_path.busy = rx_busy_in;

	// ------------------------------------------------------------
	// Path controllers
	// ------------------------------------------------------------
	mcr_path_ctrl u_tx_ctrl (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.path(tx_path)
	);

	mcr_path_ctrl u_rx_ctrl (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.path(rx_path)
	);

	// ------------------------------------------------------------
	// Soft reset sequencer
	// ------------------------------------------------------------
	// timed soft reset state
	// no EEPROM reload is requested here
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			soft_rst_reg <= 1'b0;
			rst_cnt_reg <= '0;
		end else if (rst_start) begin
			soft_rst_reg <= 1'b1;
			rst_cnt_reg <= CNT_W'(SOFT_RESET_CYCLES);
		end else if (soft_rst_reg) begin
			// hardware clears the bit when done
			if (rst_cnt_reg == CNT_W'(1)) begin
				soft_rst_reg <= 1'b0;
			end
			rst_cnt_reg <= rst_cnt_reg - CNT_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Software interrupt request
	// ------------------------------------------------------------
	// sticky request; a new trigger beats the acknowledge
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			soft_irq_pend_reg <= 1'b0;
		end else if (wr_hit && cmd_bit(reg_wdata_in, mcr_pkg::SOFT_IRQ_TRIGGER_BIT)) begin
			soft_irq_pend_reg <= 1'b1;
		end else if (soft_irq_ack_in || soft_rst_reg || rst_start) begin
			// Soft reset returns the request to its reset value from its first cycle
			soft_irq_pend_reg <= 1'b0;
		end
	end

	assign soft_irq_req_out = soft_irq_pend_reg && soft_irq_mask_in;

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	// Registered read data, one cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_reg <= mcr_pkg::COMMAND_REG_RESET;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= reg_rd_in;
			// strobes and unused bits read zero
			rdata_reg <= mcr_pkg::COMMAND_REG_RESET;
			if (reg_rd_in && (reg_addr_in == mcr_pkg::COMMAND_REG_OFFSET)) begin
				rdata_reg[mcr_pkg::SOFT_RESET_BIT] <= soft_rst_reg;
				rdata_reg[mcr_pkg::RECEIVE_RUN_BIT] <= rx_path.active;
				rdata_reg[mcr_pkg::TRANSMIT_RUN_BIT] <= tx_path.active;
			end
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_rd_valid_out = rd_valid_reg;
	assign soft_reset_out = soft_rst_reg;
	assign tx_run_out = tx_path.active;
	assign rx_run_out = rx_path.active;
	assign tx_stop_req_out = tx_path.stop_req;
	assign rx_stop_req_out = rx_path.stop_req;
	assign tx_abort_out = tx_path.abort;
	assign rx_abort_out = rx_path.abort;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_SOFT_RESET_BOTH_PATHS:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		$rose(soft_rst_reg) |-> tx_abort_out && rx_abort_out && !tx_run_out && !rx_run_out)
	else $error("soft reset did not reset both paths");

	AST_SOFT_RESET_SELF_CLEAR:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		$rose(soft_rst_reg) |-> soft_rst_reg [*2] ##[1:RST_WAIT] !soft_rst_reg)
	else $error("soft reset bit did not clear in time");

	AST_SOFT_IRQ_RAISE:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_hit && reg_wdata_in[mcr_pkg::SOFT_IRQ_TRIGGER_BIT] && soft_irq_mask_in)
		|=> soft_irq_req_out || !soft_irq_mask_in)
	else $error("software interrupt not raised");

	AST_SOFT_IRQ_MASKED:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!soft_irq_mask_in |-> !soft_irq_req_out)
	else $error("masked software interrupt reached output");

	AST_STROBES_READ_ZERO:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		reg_rd_valid_out |-> (reg_rdata_out & 32'hFFFF_FEFA) == 32'h0000_0000)
	else $error("write-only or unused bits read nonzero");

	AST_RUN_READBACK:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(reg_rd_in && reg_addr_in == mcr_pkg::COMMAND_REG_OFFSET)
		|=> reg_rdata_out[mcr_pkg::TRANSMIT_RUN_BIT] == $past(tx_run_out)
		&& reg_rdata_out[mcr_pkg::RECEIVE_RUN_BIT] == $past(rx_run_out))
	else $error("run bits do not reflect path state");

	AST_ZERO_WRITE_INERT:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_hit && reg_wdata_in == 32'h0000_0000)
		|=> !tx_abort_out && !rx_abort_out && !soft_reset_out)
	else $error("zero write started an action");

	AST_RX_DISABLE_WINS:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_hit && reg_wdata_in[mcr_pkg::RECEIVE_STOP_BIT]
		&& reg_wdata_in[mcr_pkg::RECEIVE_RUN_BIT] && !rx_run_out) |=> !rx_run_out)
	else $error("receive enable not ignored beside disable");

	AST_SOFT_RESET_CLEARS_IRQ:
	assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(rst_start && !reg_wdata_in[mcr_pkg::SOFT_IRQ_TRIGGER_BIT]) |=> !soft_irq_req_out)
	else $error("soft reset left the software interrupt pending");
endmodule
`default_nettype wire

//--- placeholder_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// ------------------------------------------------------------
	// Signals and model state
	// ------------------------------------------------------------
	localparam int SR_N = 4; // Shortened soft reset span
	logic ref_clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic wr = 1'b0, rd = 1'b0, tx_busy = 1'b0, rx_busy = 1'b0, mask = 1'b0, ack = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic vld, irq, srst, tx_run, rx_run, tx_stop, rx_stop, tx_ab, rx_ab;
	int n_mismatch = 0, num_checks = 0, seed = 36744;
	// Path states: 0 idle, 1 active, 2 stopping
	int m_tx = 0, m_rx = 0, m_sr = 0, m_pend = 0, m_atx = 0, m_arx = 0, m_vld = 0;
	logic [31:0] m_rdata = 32'h0000_0000;
	// Clock: 100 MHz
	always #5 ref_clk_in = ~ref_clk_in;
	mcr_command_reg #(.SOFT_RESET_CYCLES(SR_N)) DUT (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_rd_valid_out(vld), .tx_busy_in(tx_busy), .rx_busy_in(rx_busy),
		.soft_irq_mask_in(mask), .soft_irq_ack_in(ack), .soft_irq_req_out(irq),
		.soft_reset_out(srst), .tx_run_out(tx_run), .rx_run_out(rx_run),
		.tx_stop_req_out(tx_stop), .rx_stop_req_out(rx_stop),
		.tx_abort_out(tx_ab), .rx_abort_out(rx_ab)
	);
	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	// Next path state; abort wins, a stop waits for the packet end
	function automatic int path_next(int st, bit acc, bit en, bit dis, bit ab, bit busy);
		if (ab) return 0;
		if (st == 2) return busy ? 2 : 0;
		if (acc && dis) return (st == 1) ? 2 : st;
		if (acc && en && st == 0) return 1;
		return st;
	endfunction
	// Model steps on the same edge as the design, reading state before updating it
	always @(posedge ref_clk_in or negedge arst_n_in) begin
		bit acc, srw;
		if (!arst_n_in) begin
			{m_tx, m_rx, m_sr, m_pend, m_atx, m_arx, m_vld} = '0;
			m_rdata = 32'h0000_0000;
		end else begin
			acc = wr && addr == 8'h00 && m_sr == 0;
			srw = acc && wdata[mcr_pkg::SOFT_RESET_BIT];
			m_rdata = 32'h0000_0000;
			if (rd && addr == 8'h00) begin
				m_rdata[mcr_pkg::SOFT_RESET_BIT] = m_sr > 0;
				m_rdata[mcr_pkg::RECEIVE_RUN_BIT] = m_rx != 0;
				m_rdata[mcr_pkg::TRANSMIT_RUN_BIT] = m_tx != 0;
			end
			m_vld = rd;
			m_atx = acc && (wdata[mcr_pkg::TRANSMIT_PATH_RESET_BIT] || srw);
			m_arx = acc && (wdata[mcr_pkg::RECEIVE_PATH_RESET_BIT] || srw);
			m_tx = path_next(m_tx, acc, wdata[0], wdata[1], m_atx != 0, tx_busy);
			m_rx = path_next(m_rx, acc, wdata[2], wdata[3], m_arx != 0, rx_busy);
			m_pend = (acc && wdata[7]) ? 1 : (srw || m_sr > 0 || ack) ? 0 : m_pend;
			m_sr = srw ? SR_N : (m_sr > 0) ? m_sr - 1 : 0;
		end
	end
	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One cycle: go to the falling edge, compare everything, caller then drives
	task automatic cyc();
		@(negedge ref_clk_in);
		chk("rdata", m_rdata, rdata);
		chk("rd_valid", m_vld, vld);
		chk("soft_reset", m_sr > 0, srst);
		chk("irq_req", m_pend && mask, irq);
		chk("tx_run", m_tx != 0, tx_run);
		chk("rx_run", m_rx != 0, rx_run);
		chk("tx_stop", m_tx == 2, tx_stop);
		chk("rx_stop", m_rx == 2, rx_stop);
		chk("tx_abort", m_atx, tx_ab);
		chk("rx_abort", m_arx, rx_ab);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		wr = 1'b1;
		addr = a;
		wdata = d;
		cyc();
		wr = 1'b0;
		// Let an edge pass so a following write never re-raises the strobe at once
		cyc();
	endtask
	task automatic rd_reg(input logic [7:0] a);
		rd = 1'b1;
		addr = a;
		cyc();
		rd = 1'b0;
		cyc();
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog, far beyond the roughly 700 cycles the tests need
	initial begin
		#200000;
		n_mismatch++;
		$display("[ERR] watchdog expected end seen hang");
		finish_test();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] en, dis, prst;
		repeat (10) cyc();
		arst_n_in = 1'b1;
		cyc();
		rd_reg(8'h00);
		// Unmapped place: write ignored, read gives zero
		wr_reg(8'h04, 32'h0000_0005);
		rd_reg(8'h04);
		$display("reset and map test done");
		// Both paths: enable, stop after packet, precedence, path reset
		for (int p = 0; p < 2; p++) begin
			en = p ? 32'h0000_0004 : 32'h0000_0001;
			dis = p ? 32'h0000_0008 : 32'h0000_0002;
			prst = p ? 32'h0000_0020 : 32'h0000_0010;
			chk("reset_done", 32'h0000_0000, {29'h0, srst, tx_ab, rx_ab});
			wr_reg(8'h00, en);
			rd_reg(8'h00);
			if (p) rx_busy = 1'b1; else tx_busy = 1'b1;
			wr_reg(8'h00, dis);
			repeat (3) cyc();
			rd_reg(8'h00);
			if (p) rx_busy = 1'b0; else tx_busy = 1'b0;
			repeat (2) cyc();
			wr_reg(8'h00, en | dis);
			wr_reg(8'h00, en);
			if (p) rx_busy = 1'b1; else tx_busy = 1'b1;
			wr_reg(8'h00, prst);
			rd_reg(8'h00);
			{tx_busy, rx_busy} = 2'b00;
			wr_reg(8'h00, dis);
			cyc();
		end
		$display("path test done");
		// Software interrupt: masked, unmasked, set against clear
		wr_reg(8'h00, 32'h0000_0080);
		cyc();
		mask = 1'b1;
		cyc();
		ack = 1'b1;
		cyc();
		wr_reg(8'h00, 32'h0000_0080);
		ack = 1'b0;
		cyc();
		wr_reg(8'h00, 32'h0000_0080);
		$display("interrupt test done");
		// Soft reset with both paths busy, write refused while it runs
		wr_reg(8'h00, 32'h0000_0005);
		{tx_busy, rx_busy} = 2'b11;
		wr_reg(8'h00, 32'h0000_0100);
		rd_reg(8'h00);
		wr_reg(8'h00, 32'h0000_0005);
		repeat (SR_N + 2) cyc();
		{tx_busy, rx_busy} = 2'b00;
		rd_reg(8'h00);
		$display("soft reset test done");
		// Unused and zero bits do nothing
		wr_reg(8'h00, 32'hFFFF_FE40);
		wr_reg(8'h00, 32'h0000_0000);
		rd_reg(8'h00);
		$display("unused bit test done");
		// Random traffic, disables only while the engine is busy
		for (int i = 0; i < 600; i++) begin
			int op;
			op = $unsigned($random(seed)) % 4;
			tx_busy = 1'($random(seed));
			rx_busy = 1'($random(seed));
			mask = 1'($random(seed));
			ack = ($unsigned($random(seed)) % 8) == 0;
			addr = (($unsigned($random(seed)) % 6) == 0) ? 8'h0C : 8'h00;
			wdata = $random(seed) & 32'h0000_00BF;
			if (($unsigned($random(seed)) % 24) == 0) wdata = 32'h0000_0100;
			if (wdata[1]) tx_busy = 1'b1;
			if (wdata[3]) rx_busy = 1'b1;
			wr = op == 0;
			rd = op == 1;
			cyc();
		end
		{wr, rd, ack} = 3'b000;
		cyc();
		$display("random test done");
		// Reset again in mid-run
		wr_reg(8'h00, 32'h0000_0085);
		arst_n_in = 1'b0;
		repeat (2) cyc();
		arst_n_in = 1'b1;
		cyc();
		rd_reg(8'h00);
		$display("second reset test done");
		finish_test();
	end
endmodule
`default_nettype wire
